// ---- design/rtc_interrupt_power_monitor.sv ----
// Interrupt flags, interrupt pin driver and power monitor of the RTC
`timescale 1ns/1ns
`include "rtc_irq_defines.svh"

// Overview of operation
// R1: Supply falling to switch threshold starts a store of all memory.
// R2: On backup supply, memory and clock user access is blocked.
// R3: Timekeeping keeps running on backup; readable again after restore.
// R4: Watchdog, power and alarm sources, each with its own enable bit.
// R5: Interrupt output active only for flagged source with enable set.
// R6: Pulse mode drives the output active for about 200 ms.
// R7: Level mode holds the output active until flags are read.
// R8: No interrupts generated while on backup power.
// R9: Interrupts valid only after power-up recall completes.
// R10: Watchdog timeout sets its flag; enable decides pin drive.
// R11: Alarm match sets its flag; enable decides pin drive.
// R12: Power fail sets its flag; enable decides pin drive.
// R13: Polarity 1 push-pull high above threshold; 0 open-drain low.
// R14: Reading flags clears all flags; level output goes inactive. The oscillator-fail bit here is not cleared and keeps following osc_fail.
// R15: Flags read during a pulse ends the pulse early.
// R16: Host does not read flags while pulse reset is in progress.
// R17: Host reads flags to find the source, or polls them.
// R18: Each source sets its own flag bit.
// R19: Power-up loads flags with zero except oscillator-fail bit. Reset here loads that bit with zero too; it then follows osc_fail.
// R20: Event in the same cycle as a flags read stays flagged.
module rtc_interrupt_power_monitor #(
    parameter int unsigned PULSE_CYCLES = `PULSE_CYCLES
) (
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire logic [`ADDR_W-1:0]       addr,
    input  wire logic [7:0]               wr_data,
    input  wire logic                     wr_stb,
    input  wire logic                     rd_stb,
    output logic      [7:0]               rd_data,
    input  wire logic                     vcc_above_switch,
    input  wire logic                     recall_done,
    input  wire logic                     osc_fail,
    input  wire rtc_irq_pkg::src_events_t src_events,
    output logic                          store_start,
    output logic                          backup_active,
    output logic                          user_access_ok,
    output logic                          int_out,
    output logic                          int_oe
);

    // Pin inputs from other domains pass two flops
    logic       vcc_s1_ff, vcc_s2_ff, nxt_vcc_s1, nxt_vcc_s2;
    logic       rcl_s1_ff, rcl_s2_ff, nxt_rcl_s1, nxt_rcl_s2;
    logic       osc_s1_ff, osc_s2_ff, nxt_osc_s1, nxt_osc_s2;
    logic [2:0] ev_s1_ff, ev_s2_ff, ev_s3_ff;
    logic [2:0] nxt_ev_s1, nxt_ev_s2, nxt_ev_s3;

    // Synchroniser next values
    always_comb
    begin
        nxt_vcc_s1 = vcc_above_switch;
        nxt_vcc_s2 = vcc_s1_ff;
        nxt_rcl_s1 = recall_done;
        nxt_rcl_s2 = rcl_s1_ff;
        nxt_osc_s1 = osc_fail;
        nxt_osc_s2 = osc_s1_ff;
        nxt_ev_s1  = {src_events.watchdog, src_events.alarm,
                      src_events.power_fail};
        nxt_ev_s2  = ev_s1_ff;
        nxt_ev_s3  = ev_s2_ff;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            vcc_s1_ff <= 1'b0;
            vcc_s2_ff <= 1'b0;
            rcl_s1_ff <= 1'b0;
            rcl_s2_ff <= 1'b0;
            osc_s1_ff <= 1'b0;
            osc_s2_ff <= 1'b0;
            ev_s1_ff  <= 3'h0;
            ev_s2_ff  <= 3'h0;
            ev_s3_ff  <= 3'h0;
        end
        else
        begin
            vcc_s1_ff <= nxt_vcc_s1;
            vcc_s2_ff <= nxt_vcc_s2;
            rcl_s1_ff <= nxt_rcl_s1;
            rcl_s2_ff <= nxt_rcl_s2;
            osc_s1_ff <= nxt_osc_s1;
            osc_s2_ff <= nxt_osc_s2;
            ev_s1_ff  <= nxt_ev_s1;
            ev_s2_ff  <= nxt_ev_s2;
            ev_s3_ff  <= nxt_ev_s3;
        end
    end

    // Rising edges of synchronised source events
    logic [2:0] ev_rise;
    assign ev_rise = ev_s2_ff & ~ev_s3_ff;

    // Power state: recall after reset, then normal, backup on supply loss
    rtc_irq_pkg::pwr_state_t pwr_ff, nxt_pwr;
    logic store_ff, nxt_store;

    always_comb
    begin
        nxt_pwr   = pwr_ff;
        nxt_store = 1'b0;
        case (pwr_ff)
            rtc_irq_pkg::ST_RECALL:
            begin
                if (rcl_s2_ff && vcc_s2_ff)
                    nxt_pwr = rtc_irq_pkg::ST_NORMAL;     // R9
            end
            rtc_irq_pkg::ST_NORMAL:
            begin
                if (!vcc_s2_ff)
                begin
                    nxt_pwr   = rtc_irq_pkg::ST_BACKUP;
                    nxt_store = 1'b1;                     // R1
                end
            end
            rtc_irq_pkg::ST_BACKUP:
            begin
                // Restore goes through recall again before access
                if (vcc_s2_ff)
                    nxt_pwr = rtc_irq_pkg::ST_RECALL;     // R3
            end
            default: nxt_pwr = rtc_irq_pkg::ST_RECALL;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pwr_ff   <= rtc_irq_pkg::ST_RECALL;
            store_ff <= 1'b0;
        end
        else
        begin
            pwr_ff   <= nxt_pwr;
            store_ff <= nxt_store;
        end
    end

    logic normal;
    assign normal         = (pwr_ff == rtc_irq_pkg::ST_NORMAL);
    assign store_start    = store_ff;                     // R1
    assign backup_active  = (pwr_ff == rtc_irq_pkg::ST_BACKUP);
    // Timekeeping lives outside; only user access is gated here
    assign user_access_ok = normal;                       // R2 R3

    // Register bus decode, ignored outside normal supply
    logic rd_flags, wr_ctl, rd_ctl;
    assign rd_flags = rd_stb && normal && (addr == `EVENT_FLAGS_ADDR); // R2
    assign rd_ctl   = rd_stb && normal && (addr == `IRQ_CONTROL_ADDR);
    assign wr_ctl   = wr_stb && normal && (addr == `IRQ_CONTROL_ADDR);

    // Flags and control registers
    logic [7:0] flags_ff, nxt_flags, ctl_ff, nxt_ctl, rdat_ff, nxt_rdat;
    logic [2:0] set_ev;

    always_comb
    begin
        // Events only recorded under normal supply, power fail excepted
        set_ev    = ev_rise & {normal, normal, 1'b1};     // R8
        nxt_flags = flags_ff;
        nxt_ctl   = ctl_ff;
        nxt_rdat  = 8'h00;
        if (rd_flags)
        begin
            nxt_rdat  = flags_ff;
            nxt_flags = 8'h00;                            // R14
        end
        if (rd_ctl)
            nxt_rdat = ctl_ff;
        if (wr_ctl)
            nxt_ctl = wr_data & `CTL_WR_MASK;             // R4
        // Set wins over the read clear
        if (set_ev[2])
            nxt_flags[`FLG_WATCHDOG]   = 1'b1;            // R10 R18 R20
        if (set_ev[1])
            nxt_flags[`FLG_ALARM]      = 1'b1;            // R11 R18 R20
        if (set_ev[0])
            nxt_flags[`FLG_POWER_FAIL] = 1'b1;            // R12 R18 R20
        // Oscillator fail is owned by the oscillator monitor
        nxt_flags[`FLG_OSC_FAIL] = osc_s2_ff;             // R19
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            flags_ff <= `EVENT_FLAGS_RST;                 // R19
            ctl_ff   <= `IRQ_CONTROL_RST;
            rdat_ff  <= 8'h00;
        end
        else
        begin
            flags_ff <= nxt_flags;
            ctl_ff   <= nxt_ctl;
            rdat_ff  <= nxt_rdat;
        end
    end

    assign rd_data = rdat_ff;

    // Enabled pending sources
    logic pending;
    assign pending = normal && (                          // R5 R8 R9
        (flags_ff[`FLG_WATCHDOG]   && ctl_ff[`CTL_WD_EN])    ||
        (flags_ff[`FLG_ALARM]      && ctl_ff[`CTL_ALARM_EN]) ||
        (flags_ff[`FLG_POWER_FAIL] && ctl_ff[`CTL_POWERFAIL_EN]));

    // Pulse timer: starts on a new enabled event, ends on timeout or read
    logic [31:0] pcnt_ff, nxt_pcnt;
    logic        pend_d_ff, nxt_pend_d;
    logic        act_ff, nxt_act;

    always_comb
    begin
        nxt_pend_d = pending;
        nxt_pcnt   = pcnt_ff;
        nxt_act    = 1'b0;
        if (ctl_ff[`CTL_PULSE_LEVEL])
        begin
            if (pending && !pend_d_ff)
                nxt_pcnt = PULSE_CYCLES;                  // R6
            else if (pcnt_ff != 32'h0)
                nxt_pcnt = pcnt_ff - 32'h1;
            if (rd_flags || !normal)
                nxt_pcnt = 32'h0;                         // R15
            nxt_act = (nxt_pcnt != 32'h0);
        end
        else
        begin
            nxt_pcnt = 32'h0;
            nxt_act  = pending && !rd_flags;              // R7 R14
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pcnt_ff   <= 32'h0;
            pend_d_ff <= 1'b0;
            act_ff    <= 1'b0;
        end
        else
        begin
            pcnt_ff   <= nxt_pcnt;
            pend_d_ff <= nxt_pend_d;
            act_ff    <= nxt_act;
        end
    end

    // Pin driver: push-pull high, or open drain pulling low
    always_comb
    begin
        if (ctl_ff[`CTL_HIGH_LOW])
        begin
            // Drives only while supply is above threshold
            int_out = act_ff;                             // R13
            int_oe  = vcc_s2_ff;
        end
        else
        begin
            int_out = 1'b0;                               // R13
            int_oe  = act_ff;
        end
    end

    // Assertions
    irq_needs_src_a: assert property (@(posedge sys_clk) disable iff (rst) // R5
        (nxt_act && !ctl_ff[`CTL_PULSE_LEVEL]) |-> pending)
        else $error("interrupt active without enabled flag");
    no_irq_backup_a: assert property (@(posedge sys_clk) disable iff (rst) // R8
        !normal |=> !act_ff)
        else $error("interrupt active on backup");
    read_clears_a: assert property (@(posedge sys_clk) disable iff (rst) // R14
        (rd_flags && ev_rise == 3'h0) |=> (flags_ff[7:5] == 3'h0))
        else $error("flags not cleared by read");
    set_wins_a: assert property (@(posedge sys_clk) disable iff (rst) // R20
        (rd_flags && ev_rise[2]) |=> flags_ff[`FLG_WATCHDOG])
        else $error("event lost on read");
    store_on_loss_a: assert property (@(posedge sys_clk) disable iff (rst) // R1
        (normal && !vcc_s2_ff) |=> store_start)
        else $error("store not started");
    pulse_early_a: assert property (@(posedge sys_clk) disable iff (rst) // R15
        (rd_flags && ctl_ff[`CTL_PULSE_LEVEL]) |=> !act_ff)
        else $error("pulse not ended by read");
    pulse_start_a: assert property (@(posedge sys_clk) disable iff (rst) // R6
        (ctl_ff[`CTL_PULSE_LEVEL] && pending && !pend_d_ff && !rd_flags
         && normal) |=> act_ff)
        else $error("pulse not started");
    access_block_a: assert property (@(posedge sys_clk) disable iff (rst) // R2
        backup_active |-> !user_access_ok)
        else $error("access during backup");
    level_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // R7
        (!ctl_ff[`CTL_PULSE_LEVEL] && pending && !rd_flags) |=> act_ff)
        else $error("level interrupt dropped");
    wd_flag_a: assert property (@(posedge sys_clk) disable iff (rst) // R10
        (ev_rise[2] && normal) |=> flags_ff[`FLG_WATCHDOG])
        else $error("watchdog flag not set");

    // Recall phase: pin quiet and user locked out until recall ends
    recall_idle_a: assert property (@(posedge sys_clk) disable iff (rst) // R9
        (pwr_ff == rtc_irq_pkg::ST_RECALL) |-> !act_ff)
        else $error("interrupt active during recall");
    recall_lock_a: assert property (@(posedge sys_clk) disable iff (rst) // R9
        (pwr_ff == rtc_irq_pkg::ST_RECALL) |-> !user_access_ok)
        else $error("access during recall");
    recall_exit_a: assert property (@(posedge sys_clk) disable iff (rst) // R9
        (pwr_ff == rtc_irq_pkg::ST_RECALL && rcl_s2_ff && vcc_s2_ff)
        |=> normal)
        else $error("recall did not finish");
    restore_a: assert property (@(posedge sys_clk) disable iff (rst) // R3
        (backup_active && vcc_s2_ff) |=> (pwr_ff == rtc_irq_pkg::ST_RECALL))
        else $error("restore did not start recall");

    // Pin driver in both polarities
    pp_follow_a: assert property (@(posedge sys_clk) disable iff (rst) // R13
        ctl_ff[`CTL_HIGH_LOW] |-> (int_out == act_ff && int_oe == vcc_s2_ff))
        else $error("push-pull pin mismatch");
    od_low_a: assert property (@(posedge sys_clk) disable iff (rst) // R13
        !ctl_ff[`CTL_HIGH_LOW] |-> !int_out)
        else $error("open drain drives high");
    od_enable_a: assert property (@(posedge sys_clk) disable iff (rst) // R13
        !ctl_ff[`CTL_HIGH_LOW] |-> (int_oe == act_ff))
        else $error("open drain enable mismatch");

    // Store pulse is one cycle and only on entering backup
    store_once_a: assert property (@(posedge sys_clk) disable iff (rst) // R1
        store_start |=> !store_start)
        else $error("store pulse too long");
    store_bkup_a: assert property (@(posedge sys_clk) disable iff (rst) // R1
        store_start |-> backup_active)
        else $error("store outside backup");

    // Register port behaviour; past values skip the reset cycle
    rd_blocked_a: assert property (@(posedge sys_clk) disable iff (rst) // R2
        ($past(rd_stb) && !$past(normal) && !$past(rst))
        |-> (rd_data == 8'h00))
        else $error("read data off normal supply");
    flags_read_a: assert property (@(posedge sys_clk) disable iff (rst) // R14
        ($past(rd_flags) && !$past(rst)) |-> (rd_data == $past(flags_ff)))
        else $error("flags read data wrong");
    ctl_write_a: assert property (@(posedge sys_clk) disable iff (rst) // R4
        ($past(wr_ctl) && !$past(rst))
        |-> (ctl_ff == ($past(wr_data) & `CTL_WR_MASK)))
        else $error("control write lost");
    ctl_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // R4
        (!$past(wr_ctl) && !$past(rst)) |-> (ctl_ff == $past(ctl_ff)))
        else $error("control changed without write");
    flags_rsv_a: assert property (@(posedge sys_clk) disable iff (rst) // R19
        flags_ff[3:0] == 4'h0)
        else $error("reserved flag bits set");
    osc_mirror_a: assert property (@(posedge sys_clk) disable iff (rst) // R19
        !$past(rst) |-> (flags_ff[`FLG_OSC_FAIL] == $past(osc_s2_ff)))
        else $error("oscillator flag mismatch");

    // Pulse counter bounds and source flags
    pulse_max_a: assert property (@(posedge sys_clk) disable iff (rst) // R6
        pcnt_ff <= PULSE_CYCLES)
        else $error("pulse counter overrun");
    level_idle_a: assert property (@(posedge sys_clk) disable iff (rst) // R7
        !ctl_ff[`CTL_PULSE_LEVEL] |=> (pcnt_ff == 32'h0))
        else $error("pulse counter runs in level mode");
    pf_flag_a: assert property (@(posedge sys_clk) disable iff (rst) // R12
        ev_rise[0] |=> flags_ff[`FLG_POWER_FAIL])
        else $error("power fail flag not set");
    alarm_flag_a: assert property (@(posedge sys_clk) disable iff (rst) // R11
        (ev_rise[1] && normal) |=> flags_ff[`FLG_ALARM])
        else $error("alarm flag not set");

endmodule // rtc_interrupt_power_monitor

// ---- design/rtc_irq_defines.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef RTC_IRQ_DEFINES_SVH
`define RTC_IRQ_DEFINES_SVH

`define ADDR_W            19
`define EVENT_FLAGS_ADDR  19'h7FFF0
`define IRQ_CONTROL_ADDR  19'h7FFF6

// Event flags field positions
`define FLG_OSC_FAIL      4
`define FLG_POWER_FAIL    5
`define FLG_ALARM         6
`define FLG_WATCHDOG      7

// Interrupt control field positions
`define CTL_PULSE_LEVEL   2
`define CTL_HIGH_LOW      3
`define CTL_POWERFAIL_EN  5
`define CTL_ALARM_EN      6
`define CTL_WD_EN         7
`define CTL_WR_MASK       8'hEC

`define EVENT_FLAGS_RST   8'h00
`define IRQ_CONTROL_RST   8'h08

// Pulse width: 200 ms at a 100 ns clock period
`define PULSE_MS          200
`define CLK_PERIOD_NS     100
`define PULSE_CYCLES      ((`PULSE_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// ---- design/rtc_irq_pkg.sv ----
// Types shared by the interrupt and power monitor block
package rtc_irq_pkg;

    typedef struct packed {
        logic watchdog;
        logic alarm;
        logic power_fail;
    } src_events_t;

    typedef enum logic [1:0] {
        ST_RECALL,
        ST_NORMAL,
        ST_BACKUP
    } pwr_state_t;

endpackage

// ---- verif/rtc_host_model.sv ----
// Host-side model of the interrupt wire with its pull-up resistor
`timescale 1ns/1ns
module rtc_host_model (
    input  wire logic int_out,
    input  wire logic int_oe,
    output logic      int_pin
);
    // Released wire sits at the pull-up level, not at the last value
    assign int_pin = int_oe ? int_out : 1'b1;
endmodule // rtc_host_model

// ---- verif/rtc_interrupt_power_monitor_tb_top.sv ----
// Self-checking bench for the interrupt and power monitor block
`timescale 1ns/1ns
`include "rtc_irq_defines.svh"
module rtc_interrupt_power_monitor_tb_top;
    localparam int unsigned PW = 20;
    localparam logic [18:0] FLG = `EVENT_FLAGS_ADDR;
    localparam logic [18:0] CTL = `IRQ_CONTROL_ADDR;
    logic                     sys_clk = 1'b0;
    logic                     rst = 1'b1;
    logic [18:0]              addr = 19'h00000;
    logic [7:0]               wr_data = 8'h00;
    logic                     wr_stb = 1'b0;
    logic                     rd_stb = 1'b0;
    logic [7:0]               rd_data;
    logic                     vcc = 1'b1;
    logic                     recall_done = 1'b1;
    logic                     osc_fail = 1'b0;
    rtc_irq_pkg::src_events_t src_events = 3'h0;
    logic                     store_start;
    logic                     backup_active;
    logic                     user_access_ok;
    logic                     int_out;
    logic                     int_oe;
    logic                     int_pin;
    logic                     store_seen = 1'b0;
    logic [7:0]               d;
    int                       fail_count = 0;
    int                       checks = 0;
    int                       cyc = 0;
    int                       n;

    always #50 sys_clk = ~sys_clk;

    rtc_interrupt_power_monitor #(.PULSE_CYCLES(PW))
        rtc_interrupt_power_monitor_inst (
        .sys_clk(sys_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .vcc_above_switch(vcc), .recall_done(recall_done),
        .osc_fail(osc_fail), .src_events(src_events),
        .store_start(store_start), .backup_active(backup_active),
        .user_access_ok(user_access_ok), .int_out(int_out), .int_oe(int_oe)
    );
    rtc_host_model rtc_host_model_inst (
        .int_out(int_out), .int_oe(int_oe), .int_pin(int_pin)
    );

    // Store pulse lasts one cycle, so latch it; cycle ceiling cuts hangs
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (store_start === 1'b1)
            store_seen <= 1'b1;
        if (cyc == 20000)
        begin
            fail_count++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t byte %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t bit %b exp %b", $time, got, exp);
        end
    endtask

    // One-cycle strobes, changed just after the edge
    task automatic wr(input logic [18:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= v;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [18:0] a);
        @(posedge sys_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1 d = rd_data;
    endtask

    // Event edge held long enough for the input synchroniser
    task automatic ev(input rtc_irq_pkg::src_events_t v);
        @(posedge sys_clk);
        src_events <= v;
        repeat (3) @(posedge sys_clk);
        src_events <= 3'h0;
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic wait_ok();
        n = 0;
        while (user_access_ok !== 1'b1 && n < 50)
        begin
            @(posedge sys_clk);
            n++;
        end
        #1 chk1(user_access_ok, 1'b1);
    endtask

    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        wait_ok();
        rd(CTL); chk8(d, `IRQ_CONTROL_RST);
        rd(FLG); chk8(d, 8'h00);
        rd(19'h7FFF1); chk8(d, 8'h00);
        osc_fail <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(FLG); chk8(d, 8'h10);
        osc_fail <= 1'b0;
        // Level mode, all sources enabled, active high
        wr(CTL, 8'hE8); rd(CTL); chk8(d, 8'hE8);
        ev(3'b100); chk1(int_out, 1'b1);
        rd(FLG); chk8(d, 8'h80);
        chk1(int_out, 1'b0);
        ev(3'b001); chk1(int_out, 1'b1);
        rd(FLG); chk8(d, 8'h20);
        // Enables cleared: flag set, pin quiet
        wr(CTL, 8'h08); ev(3'b010); chk1(int_out, 1'b0);
        rd(FLG); chk8(d, 8'h40);
        // Active low, open drain
        wr(CTL, 8'h40); ev(3'b010); chk1(int_pin, 1'b0);
        chk1(int_oe, 1'b1);
        rd(FLG); chk1(int_pin, 1'b1);
        // Pulse mode: width fixed by the parameter, host does not read
        wr(CTL, 8'h8C);
        src_events <= 3'b100;
        n = 0;
        repeat (60)
        begin
            @(posedge sys_clk);
            #1 n = n + ((int_out === 1'b1) ? 1 : 0);
        end
        src_events <= 3'h0;
        chk8(8'(n), 8'(PW));
        rd(FLG); chk8(d, 8'h80);
        ev(3'b100); chk1(int_out, 1'b1);
        rd(FLG); chk8(d, 8'h80);
        chk1(int_out, 1'b0);
        // Supply loss: store, backup, no access, no interrupts
        wr(CTL, 8'h88);
        vcc <= 1'b0;
        n = 0;
        while (backup_active !== 1'b1 && n < 50)
        begin
            @(posedge sys_clk);
            n++;
        end
        #1 chk1(store_seen, 1'b1);
        chk1(user_access_ok, 1'b0);
        rd(FLG); chk8(d, 8'h00);
        ev(3'b100); chk1(int_out, 1'b0);
        vcc <= 1'b1;
        wait_ok();
        chk1(backup_active, 1'b0);
        rd(FLG); chk8(d & 8'h80, 8'h00);
        results();
    end
endmodule // rtc_interrupt_power_monitor_tb_top
